/* File: inc/rfw_pkg.sv */
/*
  Shared constants and types for the converter wrapper port model.
  Assumes a single system clock; both ends import this package.
*/
package rfw_pkg;
  // ---------------------------------------------------------------
  // Configuration port
  // ---------------------------------------------------------------
  localparam int unsigned CFG_ADDR_W   = 18;
  localparam int unsigned CFG_DATA_W   = 32;
  localparam int unsigned CFG_STRB_W   = 4;
  localparam int unsigned CFG_WORDS    = 64;
  localparam int unsigned CFG_IDX_W    = 6;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [31:0] CFG_RST_VAL  = 32'h0000_0000;
  // Configuration clock limits in MHz; the system clock must fall inside.
  localparam int unsigned CFG_CLK_MIN_MHZ = 10;
  localparam int unsigned CFG_CLK_MAX_MHZ = 200;
  localparam int unsigned CORE_CLK_MHZ    = 125;
  // ---------------------------------------------------------------
  // Converter tiles and streams
  // ---------------------------------------------------------------
  localparam int unsigned DAC_TILES      = 4;
  localparam int unsigned DAC_PER_TILE   = 4;
  localparam int unsigned ADC_TILES      = 4;
  localparam int unsigned ADC_PER_TILE   = 4;
  localparam int unsigned SAMPLE_W       = 16;
  localparam int unsigned SAMPLES_PER_WD = 4;
  localparam int unsigned DAC_STREAMS    = DAC_TILES * DAC_PER_TILE;
  localparam int unsigned STREAM_W       = SAMPLE_W * SAMPLES_PER_WD;
  localparam int unsigned CLK_DIV        = 2;

  typedef enum logic [2:0] {
    RFW_IDLE = 3'b001,
    RFW_RESP = 3'b010,
    RFW_RDAT = 3'b100
  } rfw_cfg_state_t;
endpackage : rfw_pkg

/* File: inc/rfw_if.sv */
/*
  Interface joining the user side and the converter wrapper side.
  Assumes both ends share one clock and reset supplied by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
interface rfw_if (
  input wire logic clk,
  input wire logic arst_n
);
  import rfw_pkg::*;

  logic [CFG_ADDR_W-1:0]  awaddr;
  logic                   awvalid;
  logic                   awready;
  logic [CFG_DATA_W-1:0]  wdata;
  logic [CFG_STRB_W-1:0]  wstrb;
  logic                   wvalid;
  logic                   wready;
  logic [1:0]             bresp;
  logic                   bvalid;
  logic                   bready;
  logic [CFG_ADDR_W-1:0]  araddr;
  logic                   arvalid;
  logic                   arready;
  logic [CFG_DATA_W-1:0]  rdata;
  logic [1:0]             rresp;
  logic                   rvalid;
  logic                   rready;
  logic                   irq;
  logic                   sysref_adc;
  logic                   sysref_dac;
  logic [DAC_TILES-1:0]   dac_tile_clock_out;
  logic [DAC_STREAMS-1:0] dac_stream_reset_n;
  logic [DAC_STREAMS-1:0][STREAM_W-1:0] tdata;
  logic [DAC_STREAMS-1:0] tvalid;
  logic [DAC_STREAMS-1:0] tready;

  modport wrapper (
    input  clk, arst_n, awaddr, awvalid, wdata, wstrb, wvalid, bready,
           araddr, arvalid, rready, sysref_adc, sysref_dac,
           dac_stream_reset_n, tdata, tvalid,
    output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
           irq, dac_tile_clock_out, tready
  );
  modport user (
    input  clk, arst_n, awready, wready, bresp, bvalid, arready, rdata,
           rresp, rvalid, irq, dac_tile_clock_out, tready,
    output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid,
           rready, sysref_adc, sysref_dac, dac_stream_reset_n, tdata, tvalid
  );
endinterface : rfw_if
`default_nettype wire

/* File: src/rfw_wrapper.sv */
/*
  Converter wrapper end: configuration slave, tile clock outputs and the
  stream sinks of every up-converter of every tile in one instance.
  Assumes the user end obeys the stream reset and reference timing.
*/
`timescale 1ns/1ns
`default_nettype none
module rfw_wrapper (
  // Clock and reset
  input  wire logic CORE_CLK_I,
  input  wire logic ARST_N_I,
  // Link to the user end
  rfw_if.wrapper    LINK,
  // Converter side: samples seen by each datapath
  output logic [rfw_pkg::DAC_STREAMS-1:0][rfw_pkg::STREAM_W-1:0] CONV_DATA_O,
  output logic [rfw_pkg::DAC_STREAMS-1:0]                        CONV_LOAD_O,
  output logic                                                   SYSREF_ADC_O,
  output logic                                                   SYSREF_DAC_O
);
  import rfw_pkg::*;

  // ---------------------------------------------------------------
  // Configuration slave
  // ---------------------------------------------------------------
  rfw_cfg_state_t        state;
  rfw_cfg_state_t        next_state;
  logic [CFG_DATA_W-1:0] rd_word;
  logic [CFG_DATA_W-1:0] rdata;
  logic [CFG_DATA_W-1:0] next_rdata;
  logic                  do_write;
  logic [CFG_IDX_W-1:0]  widx;
  logic [CFG_IDX_W-1:0]  ridx;

  assign widx = LINK.awaddr[CFG_IDX_W+1:2];
  assign ridx = LINK.araddr[CFG_IDX_W+1:2];

  always_comb begin
    next_state = state;
    next_rdata = rdata;
    do_write   = 1'b0;
    case (state)
      RFW_IDLE: begin
        // write takes both address and data valid.
        if (LINK.awvalid && LINK.wvalid) begin
          do_write   = 1'b1;
          next_state = RFW_RESP;
        end else if (LINK.arvalid) begin
          next_rdata = rd_word;
          next_state = RFW_RDAT;
        end
      end
      RFW_RESP: begin
        if (LINK.bready) begin
          next_state = RFW_IDLE;
        end
      end
      RFW_RDAT: begin
        if (LINK.rready) begin
          next_state = RFW_IDLE;
        end
      end
      default: next_state = RFW_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= RFW_IDLE;
      rdata <= CFG_RST_VAL;
    end else begin
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  // In idle each write ready needs the other write valid, read ready needs no write; the handshake completes on that edge.
  assign LINK.awready = (state == RFW_IDLE) && LINK.wvalid;
  assign LINK.wready  = (state == RFW_IDLE) && LINK.awvalid;
  assign LINK.arready = (state == RFW_IDLE) && !(LINK.awvalid && LINK.wvalid);
  assign LINK.bvalid  = (state == RFW_RESP);
  assign LINK.rvalid  = (state == RFW_RDAT);
  assign LINK.rdata   = rdata;
  assign LINK.bresp   = RESP_OKAY;
  assign LINK.rresp   = RESP_OKAY;
  assign LINK.irq     = 1'b0;

  // each strobe bit gates one byte lane.
  for (genvar b = 0; b < CFG_STRB_W; b++) begin : g_lane
    // One store per lane, so that every byte has a single writing process.
    logic [7:0] lane_mem [CFG_WORDS];
    always_ff @(posedge CORE_CLK_I) begin
      if (do_write && LINK.wstrb[b]) begin
        lane_mem[widx] <= LINK.wdata[8*b +: 8];
      end
    end
    assign rd_word[8*b +: 8] = lane_mem[ridx];
  end

  // ---------------------------------------------------------------
  // Tile clocks and stream sinks
  // ---------------------------------------------------------------
  logic [DAC_TILES-1:0] clk_div;
  logic [DAC_TILES-1:0] next_clk_div;

  always_comb begin
    next_clk_div = ~clk_div;
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      clk_div <= '0;
    end else begin
      clk_div <= next_clk_div;
    end
  end
  assign LINK.dac_tile_clock_out = clk_div;

  // one generate spans every up-converter of every tile.
  for (genvar t = 0; t < DAC_TILES; t++) begin : g_tile
    // each DAC tile groups four identical up-converters.
    for (genvar c = 0; c < DAC_PER_TILE; c++) begin : g_conv
      localparam int unsigned S = t * DAC_PER_TILE + c;
      // ready is the stream reset itself, not timed to the tile clock, held off in stream reset.
      assign LINK.tready[S] = LINK.dac_stream_reset_n[S];
      // samples pass straight through, no added pipeline.
      // word carries sixteen bits per sample.
      assign CONV_DATA_O[S] = LINK.tdata[S];
      assign CONV_LOAD_O[S] = LINK.tvalid[S] && LINK.tready[S];
    end
  end

  // reference inputs are assumed already in tile zero timing.
  // forwarded unchanged for the same reason.
  assign SYSREF_ADC_O = LINK.sysref_adc;
  assign SYSREF_DAC_O = LINK.sysref_dac;
endmodule : rfw_wrapper
`default_nettype wire

/* File: src/rfw_user.sv */
/*
  User end: drives configuration requests and sample streams.
  Assumes the wrapper end answers every channel with valid and ready.
*/
`timescale 1ns/1ns
`default_nettype none
module rfw_user (
  // Clock and reset
  input  wire logic CORE_CLK_I,
  input  wire logic ARST_N_I,
  // Link to the wrapper end
  rfw_if.user       LINK,
  // Configuration commands
  input  wire logic                           CMD_VALID_I,
  input  wire logic                           CMD_WRITE_I,
  input  wire logic [rfw_pkg::CFG_ADDR_W-1:0] CMD_ADDR_I,
  input  wire logic [rfw_pkg::CFG_DATA_W-1:0] CMD_WDATA_I,
  input  wire logic [rfw_pkg::CFG_STRB_W-1:0] CMD_STRB_I,
  output logic                                CMD_READY_O,
  output logic                                CMD_DONE_O,
  output logic [rfw_pkg::CFG_DATA_W-1:0]      CMD_RDATA_O,
  // Samples and references
  input  wire logic [rfw_pkg::DAC_STREAMS-1:0][rfw_pkg::STREAM_W-1:0] SAMPLE_DATA_I,
  input  wire logic [rfw_pkg::DAC_STREAMS-1:0]                        SAMPLE_VALID_I,
  input  wire logic                                                   SYSREF_ADC_I,
  input  wire logic                                                   SYSREF_DAC_I
);
  import rfw_pkg::*;

  typedef enum logic [2:0] {
    RFU_IDLE = 3'b001,
    RFU_REQ  = 3'b010,
    RFU_WAIT = 3'b100
  } rfw_user_state_t;

  rfw_user_state_t       state;
  rfw_user_state_t       next_state;
  logic                  wr;
  logic                  next_wr;
  logic [CFG_ADDR_W-1:0] addr;
  logic [CFG_ADDR_W-1:0] next_addr;
  logic [CFG_DATA_W-1:0] wdat;
  logic [CFG_DATA_W-1:0] next_wdat;
  logic [CFG_STRB_W-1:0] strb;
  logic [CFG_STRB_W-1:0] next_strb;
  logic                  done;
  logic                  next_done;
  logic [CFG_DATA_W-1:0] rdat;
  logic [CFG_DATA_W-1:0] next_rdat;
  logic [DAC_STREAMS-1:0] rst_n;
  logic [DAC_STREAMS-1:0] next_rst_n;

  always_comb begin
    next_state = state;
    next_wr    = wr;
    next_addr  = addr;
    next_wdat  = wdat;
    next_strb  = strb;
    next_done  = 1'b0;
    next_rdat  = rdat;
    // stream resets released after clock is running.
    next_rst_n = '1;
    case (state)
      RFU_IDLE: begin
        if (CMD_VALID_I) begin
          next_wr    = CMD_WRITE_I;
          next_addr  = CMD_ADDR_I;
          next_wdat  = CMD_WDATA_I;
          next_strb  = CMD_STRB_I;
          next_state = RFU_REQ;
        end
      end
      RFU_REQ: begin
        if (wr ? (LINK.awready && LINK.wready) : LINK.arready) begin
          next_state = RFU_WAIT;
        end
      end
      RFU_WAIT: begin
        if (wr && LINK.bvalid) begin
          next_done  = 1'b1;
          next_state = RFU_IDLE;
        end else if (!wr && LINK.rvalid) begin
          next_rdat  = LINK.rdata;
          next_done  = 1'b1;
          next_state = RFU_IDLE;
        end
      end
      default: next_state = RFU_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= RFU_IDLE;
      wr    <= 1'b0;
      addr  <= '0;
      wdat  <= '0;
      strb  <= '0;
      done  <= 1'b0;
      rdat  <= '0;
      rst_n <= '0;
    end else begin
      state <= next_state;
      wr    <= next_wr;
      addr  <= next_addr;
      wdat  <= next_wdat;
      strb  <= next_strb;
      done  <= next_done;
      rdat  <= next_rdat;
      rst_n <= next_rst_n;
    end
  end

  assign CMD_READY_O  = (state == RFU_IDLE);
  assign CMD_DONE_O   = done;
  assign CMD_RDATA_O  = rdat;
  assign LINK.awaddr  = addr;
  assign LINK.araddr  = addr;
  assign LINK.wdata   = wdat;
  assign LINK.wstrb   = strb;
  assign LINK.awvalid = (state == RFU_REQ) && wr;
  assign LINK.wvalid  = (state == RFU_REQ) && wr;
  assign LINK.arvalid = (state == RFU_REQ) && !wr;
  assign LINK.bready  = (state == RFU_WAIT);
  assign LINK.rready  = (state == RFU_WAIT);
  assign LINK.dac_stream_reset_n = rst_n;
  // sample words are sixteen bits per sample.
  assign LINK.tdata   = SAMPLE_DATA_I;
  assign LINK.tvalid  = SAMPLE_VALID_I & rst_n;
  // ADC reference driven in tile zero timing.
  assign LINK.sysref_adc = SYSREF_ADC_I;
  // DAC reference driven in tile zero timing.
  assign LINK.sysref_dac = SYSREF_DAC_I;
endmodule : rfw_user
`default_nettype wire

/* File: verification/rfw_monitor.sv */
/*
  Checker on the link between the user end and the wrapper end.
  Assumes the bench instantiates it beside the interface, same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rfw_monitor (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   arst_n,
  // Configuration channels
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic [1:0]             bresp,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic                   arvalid,
  input wire logic                   arready,
  input wire logic [1:0]             rresp,
  input wire logic                   rvalid,
  input wire logic                   rready,
  // Tiles and streams
  input wire logic [rfw_pkg::DAC_TILES-1:0]   dac_tile_clock_out,
  input wire logic [rfw_pkg::DAC_STREAMS-1:0] dac_stream_reset_n,
  input wire logic [rfw_pkg::DAC_STREAMS-1:0] tready
);
  import rfw_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  write_answer_a: assert property (
    awvalid && awready && wvalid && wready |=> bvalid) else $error("write not answered");
  read_answer_a: assert property (
    arvalid && arready |=> rvalid) else $error("read not answered");
  bresp_okay_a: assert property (
    bvalid |-> bresp == RESP_OKAY) else $error("write response not okay");
  rresp_okay_a: assert property (
    rvalid |-> rresp == RESP_OKAY) else $error("read response not okay");
  b_single_a: assert property (
    bvalid && bready |=> !bvalid) else $error("write response repeated");
  r_single_a: assert property (
    rvalid && rready |=> !rvalid) else $error("read response repeated");
  tile_clk_toggle_a: assert property (
    $past(arst_n) |-> dac_tile_clock_out == ~$past(dac_tile_clock_out))
    else $error("tile clock did not toggle");
  ready_gate_a: assert property (
    (tready & ~dac_stream_reset_n) == '0) else $error("ready while stream in reset");
endmodule : rfw_monitor
`default_nettype wire

/* File: verification/rf_converter_wrapper_ports_bench.sv */
/*
  Bench joining both ends through the interface and checking their ports.
  Assumes one 125 MHz clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", what, exp, got); end end
module rf_converter_wrapper_ports_bench;
  import rfw_pkg::*;
  logic                                 core_clk, arst_n, cmd_valid, cmd_write, cmd_ready;
  logic                                 cmd_done, ref_adc, ref_dac, conv_adc, conv_dac;
  logic [CFG_ADDR_W-1:0]                cmd_addr;
  logic [CFG_DATA_W-1:0]                cmd_wdata, cmd_rdata, exp_w;
  logic [CFG_STRB_W-1:0]                cmd_strb;
  logic [DAC_STREAMS-1:0][STREAM_W-1:0] smp_data, conv_data;
  logic [DAC_STREAMS-1:0]               smp_valid, conv_load;
  logic [DAC_TILES-1:0]                 tclk;
  int                                   fails, n_checks;

  rfw_if link (.clk(core_clk), .arst_n(arst_n));
  rfw_wrapper i_rfw_wrapper (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .LINK(link.wrapper),
    .CONV_DATA_O(conv_data), .CONV_LOAD_O(conv_load), .SYSREF_ADC_O(conv_adc),
    .SYSREF_DAC_O(conv_dac));
  rfw_user i_rfw_user (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .LINK(link.user),
    .CMD_VALID_I(cmd_valid), .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr),
    .CMD_WDATA_I(cmd_wdata), .CMD_STRB_I(cmd_strb), .CMD_READY_O(cmd_ready),
    .CMD_DONE_O(cmd_done), .CMD_RDATA_O(cmd_rdata), .SAMPLE_DATA_I(smp_data),
    .SAMPLE_VALID_I(smp_valid), .SYSREF_ADC_I(ref_adc), .SYSREF_DAC_I(ref_dac));
  rfw_monitor i_rfw_monitor (.clk(link.clk), .arst_n(link.arst_n), .awvalid(link.awvalid),
    .awready(link.awready), .wvalid(link.wvalid), .wready(link.wready), .bresp(link.bresp),
    .bvalid(link.bvalid), .bready(link.bready), .arvalid(link.arvalid),
    .arready(link.arready), .rresp(link.rresp), .rvalid(link.rvalid), .rready(link.rready),
    .dac_tile_clock_out(link.dac_tile_clock_out),
    .dac_stream_reset_n(link.dac_stream_reset_n), .tready(link.tready));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Bounded wait; a flag that never rises ends the run as a failure.
  task automatic wait_hi(ref logic flag);
    int n;
    n = 0;
    while (flag !== 1'b1) begin
      tick();
      n++;
      if (n > 50) begin
        fails++;
        summarize();
      end
    end
  endtask : wait_hi

  task automatic cmd(input logic wr, input logic [CFG_ADDR_W-1:0] a,
                     input logic [CFG_DATA_W-1:0] d, input logic [CFG_STRB_W-1:0] s);
    wait_hi(cmd_ready);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr  = a;
    cmd_wdata = d;
    cmd_strb  = s;
    tick();
    cmd_valid = 1'b0;
    wait_hi(cmd_done);
  endtask : cmd

  // The configuration clock period and the tile shape must stay in range.
  task automatic t_limits;
    time t0;
    @(posedge core_clk);
    t0 = $time;
    @(posedge core_clk);
    #1;
    `CHECK("cfg clk slow", 1'b1, ($time - 1 - t0) <= 1000 / CFG_CLK_MIN_MHZ)
    `CHECK("cfg clk fast", 1'b1, ($time - 1 - t0) >= 1000 / CFG_CLK_MAX_MHZ)
    `CHECK("dac per tile", 32'd4, 32'($bits(link.tready) / $bits(link.dac_tile_clock_out)))
    `CHECK("adc per tile", 1'b1, ADC_PER_TILE == 2 || ADC_PER_TILE == 4)
  endtask : t_limits

  // Samples must reach the converters in the cycle they are offered.
  task automatic t_stream;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < DAC_STREAMS; i++) begin
        smp_data[i] = {SAMPLES_PER_WD{16'(16'hA000 + i * 16'h0111 + k)}};
      end
      smp_valid = k ? 16'h5A3C : 16'hFFFF;
      #1;
      `CHECK("ready", {DAC_STREAMS{1'b1}}, link.tready)
      `CHECK("conv data", smp_data, conv_data)
      `CHECK("conv load", smp_valid, conv_load)
      `CHECK("width", 32'(16 * SAMPLES_PER_WD), 32'($bits(link.tdata[0])))
      tick();
    end
    smp_valid = '0;
  endtask : t_stream

  task automatic t_tile_clk;
    for (int k = 0; k < 3; k++) begin
      tclk = link.dac_tile_clock_out;
      `CHECK("tiles alike", 1'b1, tclk == '0 || tclk == '1)
      tick();
      `CHECK("tile clock", ~tclk, link.dac_tile_clock_out)
    end
  endtask : t_tile_clk

  task automatic t_sysref;
    for (int k = 0; k < 4; k++) begin
      ref_adc = k[0];
      ref_dac = k[1];
      tick();
      `CHECK("ref adc", ref_adc, conv_adc)
      `CHECK("ref dac", ref_dac, conv_dac)
    end
  endtask : t_sysref

  // Every strobe code on its own word; reads alias through upper address bits.
  task automatic t_strobe;
    for (int s = 0; s < 16; s++) begin
      cmd(1'b1, 18'(s * 4), 32'hFFFF_FFFF, 4'hF);
      cmd(1'b1, 18'(s * 4), 32'h5A3C_9612, 4'(s));
      cmd(1'b0, 18'(32'h3_0000 + s * 4), 32'h0, 4'h0);
      for (int b = 0; b < 4; b++) begin
        exp_w[8*b +: 8] = s[b] ? 8'(32'h5A3C_9612 >> (8 * b)) : 8'hFF;
      end
      `CHECK("strobe merge", exp_w, cmd_rdata)
    end
  endtask : t_strobe

  task automatic t_reset_mid;
    arst_n = 1'b0;
    tick();
    `CHECK("ready in reset", {DAC_STREAMS{1'b0}}, link.tready)
    `CHECK("done in reset", 1'b0, cmd_done)
    `CHECK("clock in reset", {DAC_TILES{1'b0}}, link.dac_tile_clock_out)
    arst_n = 1'b1;
    tick();
    `CHECK("ready after", {DAC_STREAMS{1'b1}}, link.tready)
    cmd(1'b1, 18'h0_0100, 32'hC3C3_1E1E, 4'hF);
    cmd(1'b0, 18'h0_0100, 32'h0, 4'h0);
    `CHECK("word 0", 32'hC3C3_1E1E, cmd_rdata)
  endtask : t_reset_mid

  initial begin
    fails = 0;
    n_checks = 0;
    arst_n = 1'b0;
    {cmd_valid, cmd_write, ref_adc, ref_dac} = '0;
    cmd_addr = '0;
    cmd_wdata = '0;
    cmd_strb = '0;
    smp_data = '0;
    smp_valid = '0;
    repeat (2) tick();
    arst_n = 1'b1;
    tick();
    t_limits();
    t_stream();
    t_tile_clk();
    t_sysref();
    t_strobe();
    t_reset_mid();
    summarize();
  end
endmodule : rf_converter_wrapper_ports_bench
`default_nettype wire
